// *** rtl/mpw_pkg.sv ***
package mpw_pkg;

    // ----------------------------------------------------------------
    // widths and counts
    // ----------------------------------------------------------------
    localparam int MPW_COUNT_W = 15;
    localparam int MPW_DUTY_W = 16;
    localparam int MPW_PAIRS = 4;
    localparam int MPW_POST_W = 4;
    localparam int MPW_PRE_W = 6;

    // ----------------------------------------------------------------
    // prescaler: last count of each ratio, half-way count of 4, 16 and 64
    // ----------------------------------------------------------------
    localparam logic [5:0] MPW_LAST_1 = 6'h00;
    localparam logic [5:0] MPW_LAST_4 = 6'h03;
    localparam logic [5:0] MPW_LAST_16 = 6'h0f;
    localparam logic [5:0] MPW_LAST_64 = 6'h3f;
    localparam logic [5:0] MPW_MID_4 = 6'h01;
    localparam logic [5:0] MPW_MID_16 = 6'h07;
    localparam logic [5:0] MPW_MID_64 = 6'h1f;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [14:0] MPW_PERIOD_RST = 15'h0000;
    localparam logic [14:0] MPW_COUNT_RST = 15'h0000;
    localparam logic [15:0] MPW_DUTY_RST = 16'h0000;
    localparam logic [3:0] MPW_POST_RST = 4'h0;

    typedef enum logic [1:0] {
        MPW_FREE = 2'b00,
        MPW_SINGLE = 2'b01,
        MPW_UPDOWN = 2'b10,
        MPW_DOUBLE = 2'b11
    } mpw_mode_type;

    typedef enum logic [1:0] {
        MPW_PRE_1 = 2'b00,
        MPW_PRE_4 = 2'b01,
        MPW_PRE_16 = 2'b10,
        MPW_PRE_64 = 2'b11
    } mpw_pre_type;

endpackage

// *** rtl/mpw_prescale.sv ***
`timescale 1ns/10ps
module mpw_prescale
    import mpw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic clr,
    input wire logic [1:0] sel,
    output logic tick,
    output logic mid
);

    typedef struct packed {
        logic [MPW_PRE_W-1:0] cnt;
    } mpw_pre_state_type;

    mpw_pre_state_type s_r;
    mpw_pre_state_type s_nxt;

    // ----------------------------------------------------------------
    // ratio decoding
    // ----------------------------------------------------------------
    function automatic logic [5:0] last_of(input logic [1:0] k);
        case (k)
            MPW_PRE_1: last_of = MPW_LAST_1;
            MPW_PRE_4: last_of = MPW_LAST_4;
            MPW_PRE_16: last_of = MPW_LAST_16;
            default: last_of = MPW_LAST_64;
        endcase
    endfunction

    function automatic logic [5:0] mid_of(input logic [1:0] k);
        case (k)
            MPW_PRE_4: mid_of = MPW_MID_4;
            MPW_PRE_16: mid_of = MPW_MID_16;
            default: mid_of = MPW_MID_64;
        endcase
    endfunction

    // divide the instruction clock; mid marks the half-step point,
    // absent at 1:1 so the half-step bit then rounds to the next count
    always_comb
    begin
        s_nxt = s_r;
        tick = 1'b0;
        mid = 1'b0;
        if (clr)
        begin
            s_nxt.cnt = '0;
        end
        else if (en)
        begin
            mid = (sel != MPW_PRE_1) && (s_r.cnt == mid_of(sel));
            if (s_r.cnt == last_of(sel))
            begin
                tick = 1'b1;
                s_nxt.cnt = '0;
            end
            else
            begin
                s_nxt.cnt = s_r.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

endmodule

// *** rtl/mpw_timebase.sv ***
`timescale 1ns/10ps
// How it works
// - up/down modes: count rises to period, then falls from next edge
// - count_down_flag reads one while falling, zero while rising
// - mode 10: event when count reaches zero and turns up; postscalable
// - mode 11: event at zero and at period match; postscaler unused
// - input clock prescaled 1, 4, 16 or 64 by a two-bit select
// - count or control writes and reset clear both scalers; control writes keep the count
// - mode 00 match and mode 10 zero events divided 1:1 up to 1:16 by four-bit postscaler
// - 15-bit period buffered; loads at wrap or, in up/down, at zero
// - while stopped the period buffer copies straight to active period
// - edge modes: output active at count zero, inactive at duty match
// - edge: duty zero never active, duty above period always active
// - up/down: active on duty match falling, inactive on match rising
// - centre: duty zero never active, duty equal period always active
// - four 16-bit duties; low bit places the edge on a half step
// - each duty has a written buffer and an active compare value
// - edge: duty loads at wrap; stopped and not inhibited, continuously
// - up/down loads at zero, double also at match, always when stopped
// - instant apply puts a written duty straight into the comparator
// - instant apply stretches, shortens or starts the running pulse
// - duty n drives pair n, low pin the complement of the high pin
// - pair complementary while its independent bit is clear; reset so
// - mode 00: wrap to zero after match, event per match, postscalable
// - mode 01: wrap after match, clear run, one event, no postscale
// - period zero stops count and events and, while running, freezes period reloads
module mpw_timebase
    import mpw_pkg::*;
#(
    parameter int CW = MPW_COUNT_W,
    parameter int DW = MPW_DUTY_W,
    parameter int NPAIR = MPW_PAIRS
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctrl_wr,
    input wire logic ctrl_run,
    input wire logic [1:0] ctrl_mode,
    input wire logic [1:0] input_prescale_select,
    input wire logic [3:0] match_postscale_select,
    input wire logic count_wr,
    input wire logic [CW-1:0] count_wdata,
    input wire logic period_wr,
    input wire logic [CW-1:0] period_wdata,
    input wire logic [NPAIR-1:0] duty_wr,
    input wire logic [DW-1:0] duty_wdata,
    input wire logic buffer_update_inhibit,
    input wire logic instant_duty_apply,
    input wire logic [NPAIR-1:0] pair_independent_select,
    output logic [CW-1:0] timebase_count,
    output logic count_down_flag,
    output logic timebase_run,
    output logic [CW-1:0] period_value,
    output logic timebase_event,
    output logic [NPAIR-1:0] pair_high_out,
    output logic [NPAIR-1:0] pair_low_out
);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    if (DW != CW + 1)
        $error("duty width must be count width plus one");
    if (NPAIR < 1 || NPAIR > MPW_PAIRS)
        $error("pair count out of range");

    typedef struct packed {
        logic [CW-1:0] count;
        logic down;
        logic run;
        logic half;
        logic [1:0] mode;
        logic [1:0] pre_sel;
        logic [MPW_POST_W-1:0] post_sel;
        logic [MPW_POST_W-1:0] post_cnt;
        logic [CW-1:0] per_buf;
        logic [CW-1:0] per_act;
        logic [NPAIR-1:0][DW-1:0] duty_buf;
        logic [NPAIR-1:0][DW-1:0] duty_act;
        logic evt;
        logic [NPAIR-1:0] hi;
        logic [NPAIR-1:0] lo;
    } mpw_state_type;

    mpw_state_type s_r;
    mpw_state_type s_nxt;
    logic tick;
    logic mid;
    logic scl_clr;

    // both scalers restart on count or control writes
    assign scl_clr = ctrl_wr || count_wr;

    // ----------------------------------------------------------------
    // input prescaler
    // ----------------------------------------------------------------
    mpw_prescale u_pre (
        .clk(clk),
        .rst_n(rst_n),
        .en(s_r.run),
        .clr(scl_clr),
        .sel(s_r.pre_sel),
        .tick(tick),
        .mid(mid)
    );

    // ----------------------------------------------------------------
    // comparator: {count, half} against the 16-bit duty
    // ----------------------------------------------------------------
    function automatic logic pair_on(
        input logic [DW-1:0] duty,
        input logic [DW-1:0] pos,
        input logic [CW-1:0] per,
        input logic centre
    );
        logic lt;
        lt = pos < duty;
        if (centre)
            pair_on = (duty != '0) && (lt || duty[DW-1:1] >= per);
        else
            pair_on = lt;
    endfunction

    // ----------------------------------------------------------------
    // time base, scalers, buffers and outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        logic at_per;
        logic per_zero;
        logic step;
        logic centre;
        logic hit;
        logic scaled;
        logic ld;
        logic on;
        at_per = s_r.count == s_r.per_act;
        per_zero = s_r.per_act == '0;
        centre = s_r.mode[1];
        hit = 1'b0;
        scaled = 1'b0;
        ld = 1'b0;
        on = 1'b0;
        s_nxt = s_r;
        s_nxt.evt = 1'b0;
        // a count or control write in the same cycle takes the edge, so no advance races it
        step = s_r.run && tick && !per_zero && !scl_clr;

        if (step)
        begin
            case (s_r.mode)
                MPW_FREE, MPW_SINGLE:
                begin
                    s_nxt.down = 1'b0;
                    if (at_per)
                    begin
                        s_nxt.count = '0;
                        hit = 1'b1;
                        ld = 1'b1;
                        scaled = (s_r.mode == MPW_FREE);
                        if (s_r.mode == MPW_SINGLE)
                            s_nxt.run = 1'b0;
                    end
                    else
                    begin
                        s_nxt.count = s_r.count + CW'(1);
                    end
                end
                default:
                begin
                    if (!s_r.down)
                    begin
                        if (at_per)
                        begin
                            s_nxt.down = 1'b1;
                            s_nxt.count = s_r.count - CW'(1);
                            if (s_r.mode == MPW_DOUBLE)
                            begin
                                hit = 1'b1;
                                ld = 1'b1;
                            end
                        end
                        else
                        begin
                            s_nxt.count = s_r.count + CW'(1);
                        end
                    end
                    else if (s_r.count == '0)
                    begin
                        s_nxt.down = 1'b0;
                        s_nxt.count = s_r.count + CW'(1);
                        ld = 1'b1;
                    end
                    else
                    begin
                        s_nxt.count = s_r.count - CW'(1);
                        if (s_r.count == CW'(1))
                        begin
                            hit = 1'b1;
                            scaled = (s_r.mode == MPW_UPDOWN);
                        end
                    end
                end
            endcase
        end

        // half-step phase within one count
        if (scl_clr || tick)
            s_nxt.half = 1'b0;
        else if (mid)
            s_nxt.half = 1'b1;

        // postscaler: ratio is select plus one
        if (scl_clr)
            s_nxt.post_cnt = '0;
        else if (hit)
        begin
            if (!scaled)
                s_nxt.evt = 1'b1;
            else if (s_r.post_cnt == s_r.post_sel)
            begin
                s_nxt.evt = 1'b1;
                s_nxt.post_cnt = '0;
            end
            else
                s_nxt.post_cnt = s_r.post_cnt + MPW_POST_W'(1);
        end

        // control and count writes; the count is not touched by control
        if (ctrl_wr)
        begin
            s_nxt.run = ctrl_run;
            s_nxt.mode = ctrl_mode;
            s_nxt.pre_sel = input_prescale_select;
            s_nxt.post_sel = match_postscale_select;
        end
        if (count_wr)
            s_nxt.count = count_wdata;

        // period double buffer
        if (period_wr)
            s_nxt.per_buf = period_wdata;
        if (!s_r.run)
            s_nxt.per_act = s_r.per_buf;
        else if (ld)
            s_nxt.per_act = s_r.per_buf;

        // duty double buffers; instant apply bypasses the reload point
        for (int i = 0; i < NPAIR; i++)
        begin
            if (duty_wr[i])
                s_nxt.duty_buf[i] = duty_wdata;
            if (!s_r.run)
            begin
                if (centre || !buffer_update_inhibit)
                    s_nxt.duty_act[i] = s_r.duty_buf[i];
            end
            else if (ld)
                s_nxt.duty_act[i] = s_r.duty_buf[i];
            if (duty_wr[i] && instant_duty_apply)
                s_nxt.duty_act[i] = duty_wdata;
        end

        // level compare, so an instant write reshapes the live pulse
        for (int i = 0; i < NPAIR; i++)
        begin
            on = pair_on(s_r.duty_act[i], {s_r.count, s_r.half},
                s_r.per_act, centre);
            s_nxt.hi[i] = on;
            s_nxt.lo[i] = pair_independent_select[i] ? on : !on;
        end
    end

    // reset leaves every pair complementary with its high pin inactive
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.count <= MPW_COUNT_RST;
            s_r.per_buf <= MPW_PERIOD_RST;
            s_r.per_act <= MPW_PERIOD_RST;
            s_r.post_cnt <= MPW_POST_RST;
            s_r.lo <= '1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign timebase_count = s_r.count;
    assign count_down_flag = s_r.down;
    assign timebase_run = s_r.run;
    assign period_value = s_r.per_act;
    assign timebase_event = s_r.evt;
    assign pair_high_out = s_r.hi;
    assign pair_low_out = s_r.lo;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_clean_tick;
        s_r.run && tick && !scl_clr && (s_r.per_act != '0);
    endsequence

    sequence s_top_up;
        s_clean_tick and (s_r.mode[1] && !s_r.down &&
            s_r.count == s_r.per_act);
    endsequence

    AST_UPDOWN_TURN: assert property (s_top_up |=>
        (count_down_flag && timebase_count == $past(s_r.count) - CW'(1)))
        else $error("up/down count did not turn at period");

    AST_EDGE_NEVER_DOWN: assert property (!s_r.mode[1] && !ctrl_wr
        |=> !count_down_flag || $past(count_down_flag))
        else $error("direction flag rose in an edge mode");

    AST_ZERO_EVENT: assert property ((s_clean_tick and
        (s_r.mode == MPW_UPDOWN && s_r.down && s_r.count == CW'(1) &&
        s_r.post_sel == '0)) |=> timebase_event && timebase_count == '0)
        else $error("missing zero event in up/down mode");

    AST_DOUBLE_MATCH_EVENT: assert property ((s_top_up and
        (s_r.mode == MPW_DOUBLE)) |=> timebase_event)
        else $error("missing period event in double mode");

    AST_CTRL_KEEPS_COUNT: assert property (ctrl_wr && !count_wr
        |=> timebase_count == $past(s_r.count) && s_r.post_cnt == '0)
        else $error("control write disturbed the count");

    AST_SINGLE_STOP: assert property ((s_clean_tick and
        (s_r.mode == MPW_SINGLE && s_r.count == s_r.per_act)) |=>
        !timebase_run && timebase_count == '0 && timebase_event ##1
        !timebase_event)
        else $error("single shot did not stop after match");

    AST_IDLE_PERIOD_COPY: assert property (!s_r.run |=>
        period_value == $past(s_r.per_buf))
        else $error("stopped period not copied from buffer");

    AST_ZERO_PERIOD_HOLD: assert property (s_r.run &&
        s_r.per_act == '0 && !scl_clr |=> $stable(s_r.count) &&
        !timebase_event)
        else $error("zero period still counting");

    AST_PAIR_COMPLEMENT: assert property (
        !$past(pair_independent_select[0]) |->
        pair_low_out[0] == !pair_high_out[0])
        else $error("pair one not complementary");

    AST_EDGE_ZERO_DUTY: assert property (!s_r.mode[1] &&
        s_r.duty_act[0] == '0 |=> !pair_high_out[0])
        else $error("zero duty drove pair one active");

    AST_INSTANT_APPLY: assert property (duty_wr[0] &&
        instant_duty_apply |=> s_r.duty_act[0] == $past(duty_wdata))
        else $error("instant duty write not applied");

endmodule

// *** tb/mpw_gate_model.sv ***
`timescale 1ns/10ps
module mpw_gate_model
    import mpw_pkg::*;
(
    input wire logic clk,
    input wire logic [3:0] gate_high,
    input wire logic [3:0] gate_low,
    input wire logic [3:0] indep,
    output int overlap_cnt
);
    logic [3:0] indep_q;

    // the outputs follow the select seen at the rising edge, so the
    // leg is judged against that copy, not the one just driven
    always @(posedge clk)
    begin
        indep_q <= indep;
    end

    // ------------------------------------------------------------
    // inverter leg watch
    // ------------------------------------------------------------
    // both switches of a complementary leg on shorts the rail, so
    // every such cycle is counted; sampled mid-cycle to stay off
    // the edge where the outputs move
    initial overlap_cnt = 0;
    always @(negedge clk)
    begin
        if (|(gate_high & gate_low & ~indep_q))
        begin
            overlap_cnt = overlap_cnt + 1;
        end
    end
endmodule

// *** tb/test_mpw_timebase.sv ***
`timescale 1ns/10ps
module test_mpw_timebase
    import mpw_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk, rst_n, ctrl_wr, ctrl_run, count_wr, period_wr;
    logic buffer_update_inhibit, instant_duty_apply;
    logic [1:0] ctrl_mode, input_prescale_select;
    logic [3:0] match_postscale_select, duty_wr, pair_independent_select;
    logic [14:0] count_wdata, period_wdata, timebase_count, period_value;
    logic [15:0] duty_wdata;
    logic count_down_flag, timebase_run, timebase_event;
    logic [3:0] pair_high_out, pair_low_out;
    int mismatches, checks, overlap_cnt, g, b, c, h [4];

    mpw_timebase i_dut (.clk(clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
        .ctrl_run(ctrl_run), .ctrl_mode(ctrl_mode),
        .input_prescale_select(input_prescale_select),
        .match_postscale_select(match_postscale_select),
        .count_wr(count_wr), .count_wdata(count_wdata),
        .period_wr(period_wr), .period_wdata(period_wdata),
        .duty_wr(duty_wr), .duty_wdata(duty_wdata),
        .buffer_update_inhibit(buffer_update_inhibit),
        .instant_duty_apply(instant_duty_apply),
        .pair_independent_select(pair_independent_select),
        .timebase_count(timebase_count),
        .count_down_flag(count_down_flag), .timebase_run(timebase_run),
        .period_value(period_value), .timebase_event(timebase_event),
        .pair_high_out(pair_high_out), .pair_low_out(pair_low_out));

    mpw_gate_model i_gate (.clk(clk), .gate_high(pair_high_out),
        .gate_low(pair_low_out), .indep(pair_independent_select),
        .overlap_cnt(overlap_cnt));

    // clock at 100 MHz
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // strobes rise on one falling edge and drop on the next
    task automatic ctrl(input logic r, input logic [1:0] m,
        input logic [1:0] p, input logic [3:0] q);
        @(negedge clk);
        {ctrl_run, ctrl_mode, input_prescale_select} = {r, m, p};
        match_postscale_select = q;
        ctrl_wr = 1'b1;
        @(negedge clk);
        ctrl_wr = 1'b0;
    endtask

    // a period of one is never written
    task automatic wr_period(input logic [14:0] v);
        @(negedge clk);
        period_wdata = v;
        period_wr = 1'b1;
        @(negedge clk);
        period_wr = 1'b0;
    endtask

    task automatic wr_duty(input logic [3:0] m, input logic [15:0] v);
        @(negedge clk);
        duty_wdata = v;
        duty_wr = m;
        @(negedge clk);
        duty_wr = 4'h0;
    endtask

    task automatic wr_count(input logic [14:0] v);
        @(negedge clk);
        count_wdata = v;
        count_wr = 1'b1;
        @(negedge clk);
        count_wr = 1'b0;
    endtask

    // bounded waits; a hang is left to the watchdog
    task automatic wait_count(input logic [14:0] v);
        for (int n = 0; n < 3000 && timebase_count !== v; n++)
            @(negedge clk);
    endtask

    // cycles between the next two events
    task automatic gap(output int n);
        for (int k = 0; k < 3000 && timebase_event !== 1'b1; k++)
            @(negedge clk);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (timebase_event !== 1'b1 && n < 3000);
    endtask

    // high cycles of each pair over one whole period
    task automatic hcount(input int len);
        h = '{0, 0, 0, 0};
        repeat (len)
        begin
            @(negedge clk);
            for (int i = 0; i < 4; i++)
                h[i] += pair_high_out[i];
            check(pair_low_out, 4'(~pair_high_out));
        end
    endtask

    // the four high counts packed a byte each for one compare
    function automatic logic [31:0] hpack();
        return {h[0][7:0], h[1][7:0], h[2][7:0], h[3][7:0]};
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_edge();
        check({timebase_run, period_value, pair_low_out}, 20'h0000f);
        wr_period(15'h0004);
        @(negedge clk);
        check(period_value, 15'h0004);
        wr_duty(4'h1, 16'h0004);
        wr_duty(4'h2, 16'h0000);
        wr_duty(4'h4, 16'h000a);
        wr_duty(4'h8, 16'h0007);
        ctrl(1'b1, MPW_FREE, MPW_PRE_1, 4'h0);
        gap(g);
        check(g, 5);
        hcount(5);
        check(hpack(), 32'h02000504);
        pair_independent_select = 4'h8;
        repeat (3) @(negedge clk);
        check(pair_low_out[3], pair_high_out[3]);
        pair_independent_select = 4'h0;
        for (int p = 0; p < 4; p++)
        begin
            ctrl(1'b1, MPW_FREE, p[1:0], 4'h0);
            gap(g);
            check(g, 5 * (4 ** p));
        end
        ctrl(1'b1, MPW_FREE, MPW_PRE_1, 4'hf);
        gap(g);
        check(g, 80);
        ctrl(1'b1, MPW_FREE, MPW_PRE_1, 4'h0);
        wr_period(15'h0006);
        check(period_value, 15'h0004);
        gap(g);
        check({g[15:0], 1'b0, period_value}, 32'h00070006);
        $display("test edge done");
    endtask

    task automatic t_centre();
        ctrl(1'b0, MPW_UPDOWN, MPW_PRE_1, 4'h0);
        wr_period(15'h0004);
        wr_duty(4'h1, 16'h0004);
        wr_duty(4'h2, 16'h0000);
        wr_duty(4'h4, 16'h0008);
        wr_duty(4'h8, 16'h0006);
        ctrl(1'b1, MPW_UPDOWN, MPW_PRE_1, 4'h0);
        gap(g);
        check(g, 8);
        hcount(8);
        check(hpack(), 32'h03000805);
        wait_count(15'h0004);
        @(negedge clk);
        check({count_down_flag, timebase_count}, 16'h8003);
        wait_count(15'h0000);
        @(negedge clk);
        check({count_down_flag, timebase_count}, 16'h0001);
        ctrl(1'b1, MPW_UPDOWN, MPW_PRE_1, 4'h1);
        gap(g);
        check(g, 16);
        ctrl(1'b1, MPW_DOUBLE, MPW_PRE_1, 4'h3);
        gap(b);
        gap(c);
        check({b + c, b < 8}, {8, 1'b1});
        $display("test centre done");
    endtask

    task automatic t_single();
        ctrl(1'b0, MPW_SINGLE, MPW_PRE_1, 4'h0);
        wr_count(15'h0000);
        ctrl(1'b1, MPW_SINGLE, MPW_PRE_1, 4'h5);
        gap(g);
        check(g, 3000);
        check({timebase_run, timebase_count}, 16'h0000);
        check(count_down_flag, 1'b0);
        // period zero freezes count and reloads
        wr_period(15'h0000);
        ctrl(1'b0, MPW_FREE, MPW_PRE_1, 4'h0);
        wr_count(15'h0002);
        ctrl(1'b1, MPW_FREE, MPW_PRE_1, 4'h0);
        repeat (20) @(negedge clk);
        wr_period(15'h0003);
        repeat (3) @(negedge clk);
        check({timebase_count, period_value}, {15'h2, 15'h0});
        ctrl(1'b0, MPW_FREE, MPW_PRE_1, 4'h0);
        @(negedge clk);
        check(period_value, 15'h0003);
        $display("test single done");
    endtask

    task automatic t_scaler_clear();
        wr_period(15'h0064);
        ctrl(1'b1, MPW_FREE, MPW_PRE_64, 4'h0);
        wr_count(15'h000a);
        repeat (60) @(negedge clk);
        check(timebase_count, 15'h000a);
        repeat (6) @(negedge clk);
        check(timebase_count, 15'h000b);
        ctrl(1'b0, MPW_FREE, MPW_PRE_1, 4'h0);
        ctrl(1'b0, MPW_UPDOWN, MPW_PRE_4, 4'h2);
        check(timebase_count, 15'h000b);
        $display("test scaler clear done");
    endtask

    task automatic t_duty_update();
        wr_duty(4'h1, 16'h0014);
        ctrl(1'b1, MPW_FREE, MPW_PRE_1, 4'h0);
        wait_count(15'h001e);
        wr_duty(4'h1, 16'h0064);
        repeat (3) @(negedge clk);
        check(pair_high_out[0], 1'b0);
        wait_count(15'h0000);
        wait_count(15'h0028);
        check(pair_high_out[0], 1'b1);
        instant_duty_apply = 1'b1;
        wait_count(15'h003c);
        wr_duty(4'h1, 16'h00c8);
        repeat (2) @(negedge clk);
        check(pair_high_out[0], 1'b1);
        wr_duty(4'h1, 16'h0014);
        repeat (2) @(negedge clk);
        check(pair_high_out[0], 1'b0);
        instant_duty_apply = 1'b0;
        // stopped edge mode: the inhibit bit holds the old compare value
        ctrl(1'b0, MPW_FREE, MPW_PRE_1, 4'h0);
        buffer_update_inhibit = 1'b1;
        wr_duty(4'h1, 16'h00c8);
        repeat (2) @(negedge clk);
        check(pair_high_out[0], 1'b0);
        buffer_update_inhibit = 1'b0;
        repeat (3) @(negedge clk);
        check(pair_high_out[0], 1'b1);
        $display("test duty update done");
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        {rst_n, ctrl_wr, ctrl_run, count_wr, period_wr} = 5'h0;
        {buffer_update_inhibit, instant_duty_apply} = 2'h0;
        {ctrl_mode, input_prescale_select} = 4'h0;
        {match_postscale_select, duty_wr, pair_independent_select} = 12'h0;
        {count_wdata, period_wdata, duty_wdata} = 46'h0;
        mismatches = 0;
        checks = 0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        t_edge();
        t_centre();
        t_single();
        t_scaler_clear();
        t_duty_update();
        check(overlap_cnt, 0);
        complete_run();
    end

    // the tests need about 5000 cycles
    initial
    begin
        #400000;
        mismatches++;
        complete_run();
    end
endmodule
